// ===== common/ubgd_pkg.sv
package ubgd_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_TXBUF  = 12'h004;
  localparam logic [11:0] OFS_STAT   = 12'h008;
  localparam logic [11:0] OFS_FLAGS  = 12'h00C;
  localparam logic [11:0] OFS_MASK   = 12'h010;
  localparam logic [11:0] OFS_BAUD   = 12'h014;
  // ************************************************************
  // Control fields
  // ************************************************************
  localparam int CTL_TRANSMIT_ENABLE_BIT    = 0;
  localparam int CTL_SEND_BREAK_REQUEST   = 1;
  localparam int CTL_OVR     = 2;
  localparam int CTL_BIMD    = 3;
  localparam int CTL_WAKE    = 4;
  localparam int CTL_SLEEP   = 5;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MODE_HI = 7;
  // ************************************************************
  // Flag fields
  // ************************************************************
  localparam int FLG_BREAK  = 0;
  localparam int FLG_TXDONE = 1;
  localparam int FLG_RXDATA = 2;
  localparam int FLG_WIDTH  = 3;
  // ************************************************************
  // Modes and counts
  // ************************************************************
  typedef enum logic [1:0]
  {
    UBGD_ASYNC = 2'b00,
    UBGD_LIN   = 2'b01,
    UBGD_DMX   = 2'b10
  } ubgd_mode_t;
  localparam int BREAK_ZERO_BITS = 12;
  localparam int RX_BREAK_ASYNC  = 11;
  localparam int RX_BREAK_DMX    = 23;
  localparam int DATA_BITS       = 8;
  localparam logic [15:0] BAUD_RESET = 16'h0010;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
endpackage

// ===== design/ubgd_tx.sv
`timescale 1ns/10ps
module ubgd_tx
  import ubgd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] baud_div,
  input  wire logic        enable,
  input  wire logic        break_req,
  input  wire logic        auto_break,
  input  wire logic        override,
  input  wire logic        load,
  input  wire logic [7:0]  load_data,
  output logic             line,
  output logic             busy,
  output logic             break_done,
  output logic             char_done
);
  typedef enum logic [1:0]
  {
    UBGD_TX_IDLE  = 2'b00,
    UBGD_TX_BREAK = 2'b01,
    UBGD_TX_CHAR  = 2'b10
  } ubgd_txst_t;

  ubgd_txst_t  state;
  logic [15:0] tick_cnt;
  logic [4:0]  bit_idx;
  logic [9:0]  shifter;
  logic [7:0]  held;
  wire         tick = (tick_cnt == baud_div);
  wire         go_break = load && enable && (break_req || auto_break);
  // The break frame is start, twelve zeros and stop: fourteen bit slots.
  wire [4:0]   break_last = 5'(BREAK_ZERO_BITS + 1);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state      <= UBGD_TX_IDLE;
      tick_cnt   <= 16'h0000;
      bit_idx    <= 5'h00;
      shifter    <= 10'h3FF;
      held       <= 8'h00;
      line       <= 1'b1;
      break_done <= 1'b0;
      char_done  <= 1'b0;
    end
    else
    begin
      break_done <= 1'b0;
      char_done  <= 1'b0;
      tick_cnt   <= (state == UBGD_TX_IDLE || tick) ? 16'h0000 : tick_cnt + 16'h0001;
      case (state)
        UBGD_TX_IDLE:
        begin
          bit_idx <= 5'h00;
          line <= override ? 1'b0 : 1'b1;
          if (go_break)
          begin
            held  <= load_data;
            state <= UBGD_TX_BREAK;
            line  <= 1'b0;
          end
          else if (load && enable)
          begin
            shifter <= {1'b1, load_data, 1'b0};
            state   <= UBGD_TX_CHAR;
            line    <= 1'b0;
          end
        end
        UBGD_TX_BREAK:
        begin
          if (tick)
          begin
            bit_idx <= bit_idx + 5'h01;
            line <= (bit_idx >= 5'(BREAK_ZERO_BITS)) ? 1'b1 : 1'b0;
            if (bit_idx == break_last)
            begin
              break_done <= 1'b1;
              shifter    <= {1'b1, held, 1'b0};
              bit_idx    <= 5'h00;
              line       <= 1'b0;
              state      <= UBGD_TX_CHAR;
            end
          end
        end
        UBGD_TX_CHAR:
        begin
          if (tick)
          begin
            bit_idx <= bit_idx + 5'h01;
            shifter <= {1'b1, shifter[9:1]};
            line    <= shifter[1];
            if (bit_idx == 5'(DATA_BITS + 1))
            begin
              char_done <= 1'b1;
              line      <= 1'b1;
              state     <= UBGD_TX_IDLE;
            end
          end
        end
        default:
        begin
          state <= UBGD_TX_IDLE;
        end
      endcase
    end
  end

  assign busy = (state != UBGD_TX_IDLE);
endmodule

// ===== design/ubgd_rx.sv
`timescale 1ns/10ps
module ubgd_rx
  import ubgd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] baud_div,
  input  wire logic        enable,
  input  wire logic        dmx,
  input  wire logic        at_detect,
  input  wire logic        line,
  output logic             break_event,
  output logic             byte_valid,
  output logic [7:0]       byte_data
);
  logic [15:0] tick_cnt;
  logic [4:0]  space_bits;
  logic        detected;
  logic        line_q;
  logic [3:0]  rx_idx;
  logic [8:0]  rx_shift;
  logic        rx_active;
  logic [15:0] rx_cnt;
  wire         tick = (tick_cnt == baud_div);
  wire [4:0]   limit = dmx ? 5'(RX_BREAK_DMX) : 5'(RX_BREAK_ASYNC);
  wire         reach = tick && !detected && (space_bits + 5'h01 >= limit);
  wire         rx_tick = (rx_cnt == baud_div);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tick_cnt    <= 16'h0000;
      space_bits  <= 5'h00;
      detected    <= 1'b0;
      line_q      <= 1'b1;
      break_event <= 1'b0;
    end
    else
    begin
      line_q      <= line;
      break_event <= 1'b0;
      if (!enable || line)
      begin
        tick_cnt   <= 16'h0000;
        space_bits <= 5'h00;
        detected   <= 1'b0;
        if (enable && detected && !at_detect)
        begin
          break_event <= 1'b1;
        end
      end
      else
      begin
        tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
        if (tick && !detected)
        begin
          space_bits <= space_bits + 5'h01;
        end
        if (reach)
        begin
          detected <= 1'b1;
          break_event <= at_detect;
        end
      end
    end
  end

  // Plain receiver; a break is also seen here as a framing loss and dropped.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_active  <= 1'b0;
      rx_cnt     <= 16'h0000;
      rx_idx     <= 4'h0;
      rx_shift   <= 9'h000;
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end
    else
    begin
      byte_valid <= 1'b0;
      if (!rx_active)
      begin
        rx_cnt <= {1'b0, baud_div[15:1]};
        rx_idx <= 4'h0;
        if (enable && line_q && !line)
        begin
          rx_active <= 1'b1;
        end
      end
      else
      begin
        rx_cnt <= rx_tick ? 16'h0000 : rx_cnt + 16'h0001;
        if (rx_tick)
        begin
          rx_shift <= {line, rx_shift[8:1]};
          rx_idx   <= rx_idx + 4'h1;
          if (rx_idx == 4'(DATA_BITS + 1))
          begin
            rx_active  <= 1'b0;
            byte_valid <= line;
            byte_data  <= rx_shift[8:1];
          end
        end
      end
    end
  end
endmodule

// ===== design/ubgd_top.sv
`timescale 1ns/10ps
// Functional notes
// - Fixed break: start, twelve zeros, stop.
// - Software break held by override bit.
// - Buffer write with request starts break.
// - Initiating character follows the break.
// - Request ignored in LIN and DMX.
// - Hardware clears request after break stop.
// - Idle flag tracks break like characters.
// - Count space time, set break flag.
// - Eleven bits async/LIN, twenty-three DMX.
// - Timing one: flag at detection.
// - Timing zero: flag on return idle.
// - Module stops while asleep.
// - Wake enable keeps module idle.
module ubgd_top
  import ubgd_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RXD,
  output logic             TXD,
  output logic             IRQ,
  output logic             WAKE
);
  import ubgd_pkg::*;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0]           ctrl;
  logic [15:0]          baud;
  logic [FLG_WIDTH-1:0] flags;
  logic [FLG_WIDTH-1:0] mask;
  logic [7:0]           rx_hold;
  logic                 tx_line;
  logic                 tx_busy;
  logic                 tx_break_done;
  logic                 tx_char_done;
  logic                 rx_break;
  logic                 rx_valid;
  logic [7:0]           rx_byte;
  logic                 rxd_q;

  // ************************************************************
  // Decode
  // ************************************************************
  wire        acc      = PSEL && PENABLE;
  wire        wr       = acc && PWRITE;
  wire        hit_ctrl = (PADDR == OFS_CTRL);
  wire        hit_tx   = (PADDR == OFS_TXBUF);
  wire        hit_stat = (PADDR == OFS_STAT);
  wire        hit_flg  = (PADDR == OFS_FLAGS);
  wire        hit_mask = (PADDR == OFS_MASK);
  wire        hit_baud = (PADDR == OFS_BAUD);
  wire        mapped   = hit_ctrl | hit_tx | hit_stat | hit_flg | hit_mask | hit_baud;
  wire [1:0]  mode     = ctrl[CTL_MODE_HI:CTL_MODE_LO];
  wire        auto_brk = (mode == UBGD_LIN) || (mode == UBGD_DMX);
  wire        asleep   = ctrl[CTL_SLEEP];
  wire        run      = !asleep && !ctrl[CTL_WAKE];
  wire        tx_load  = wr && hit_tx;
  wire        send_break_request_eff = ctrl[CTL_SEND_BREAK_REQUEST] && !auto_brk;
  wire [FLG_WIDTH-1:0] ev = {rx_valid, tx_char_done, rx_break};
  wire [FLG_WIDTH-1:0] clr = (wr && hit_flg) ? PWDATA[FLG_WIDTH-1:0] : {FLG_WIDTH{1'b0}};
  wire [31:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl} :
    hit_tx   ? {24'h000000, rx_hold} :
    hit_stat ? {30'h00000000, !tx_busy, rxd_q} :
    hit_flg  ? {29'h00000000, flags} :
    hit_mask ? {29'h00000000, mask} :
    hit_baud ? {16'h0000, baud} : 32'h00000000;

  // ************************************************************
  // Bus slave
  // ************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA  <= rd_mux;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ctrl <= CTRL_RESET;
      baud <= BAUD_RESET;
      mask <= {FLG_WIDTH{1'b0}};
    end
    else
    begin
      if (wr && PREADY && hit_ctrl)
      begin
        ctrl <= PWDATA[7:0];
      end
      else if (tx_break_done)
      begin
        ctrl[CTL_SEND_BREAK_REQUEST] <= 1'b0;
      end
      if (wr && PREADY && hit_baud)
      begin
        baud <= PWDATA[15:0];
      end
      if (wr && PREADY && hit_mask)
      begin
        mask <= PWDATA[FLG_WIDTH-1:0];
      end
    end
  end

  // ************************************************************
  // Sticky flags and interrupt
  // ************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      flags   <= {FLG_WIDTH{1'b0}};
      rx_hold <= 8'h00;
      IRQ     <= 1'b0;
      WAKE    <= 1'b0;
      TXD     <= 1'b1;
      rxd_q   <= 1'b1;
    end
    else
    begin
      rxd_q <= RXD;
      flags <= (flags & ~(PREADY ? clr : {FLG_WIDTH{1'b0}})) | ev;
      if (rx_valid)
      begin
        rx_hold <= rx_byte;
      end
      IRQ  <= |(flags & mask);
      WAKE <= ctrl[CTL_WAKE] && !RXD;
      TXD  <= tx_line;
    end
  end

  // ************************************************************
  // Transmit and receive
  // ************************************************************
  ubgd_tx u_tx
  (
    .clk        (CLK),
    .rst_n      (RSTN),
    .baud_div   (baud),
    .enable     (ctrl[CTL_TRANSMIT_ENABLE_BIT] && run),
    .break_req  (send_break_request_eff),
    .auto_break (auto_brk),
    .override   (ctrl[CTL_OVR] && run),
    .load       (tx_load && PREADY),
    .load_data  (PWDATA[7:0]),
    .line       (tx_line),
    .busy       (tx_busy),
    .break_done (tx_break_done),
    .char_done  (tx_char_done)
  );

  ubgd_rx u_rx
  (
    .clk         (CLK),
    .rst_n       (RSTN),
    .baud_div    (baud),
    .enable      (run),
    .dmx         (mode == UBGD_DMX),
    .at_detect   (ctrl[CTL_BIMD]),
    .line        (rxd_q),
    .break_event (rx_break),
    .byte_valid  (rx_valid),
    .byte_data   (rx_byte)
  );
endmodule

// ===== verification/ubgd_top_asserts.sv
`timescale 1ns/10ps
module ubgd_top_asserts
(
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RXD,
  input wire logic        TXD,
  input wire logic        IRQ,
  input wire logic        WAKE
);
  import ubgd_pkg::*;
  logic [2:0] mask_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // **********
  // Mask shadow
  // **********
  // The shadow follows bus writes only, so the interrupt check stays independent of the design's decoder.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      mask_q <= 3'h0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_MASK)
      mask_q <= PWDATA[2:0];
  end
  // **********
  // Properties
  // **********
  setup_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (PREADY && PADDR > OFS_BAUD |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (PREADY && PADDR <= OFS_BAUD && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access refused");
  reset_idle_a: assert property ($rose(RSTN) |-> TXD && !IRQ && !WAKE)
    else $error("outputs not idle after reset");
  wake_cause_a: assert property (RXD [*3] |=> !WAKE)
    else $error("wake without space on line");
  start_bit_a: assert property ($fell(TXD) |-> !TXD [*4])
    else $error("low bit shorter than one period");
  irq_masked_a: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !IRQ)
    else $error("interrupt while fully masked");
  cov_err_c: cover property (PREADY && PSLVERR);
  cov_irq_c: cover property ($rose(IRQ));
  cov_wake_c: cover property ($rose(WAKE));
endmodule

// ===== verification/ubgd_node.sv
`timescale 1ns/10ps
module ubgd_node
#(
  parameter int PER = 4
)
(
  input wire logic clk,
  input wire logic clr,
  input wire logic space,
  input wire logic txd,
  output logic     rxd,
  output int       max_low,
  output int       n_bytes,
  output logic [7:0] last_byte
);
  import ubgd_pkg::*;
  int         run;
  logic [7:0] b;
  assign rxd = !space;
  always_ff @(posedge clk)
  begin
    run <= (clr || txd) ? 0 : run + 1;
    if (clr)
      max_low <= 0;
    else if (!txd && run + 1 > max_low)
      max_low <= run + 1;
  end
  // **********
  // Frame receiver
  // **********
  // Sampling on the falling clock edge keeps clear of the design's own output updates.
  initial n_bytes = 0;
  always
  begin
    @(negedge txd);
    repeat (PER / 2) @(negedge clk);
    for (int i = 0; i < DATA_BITS; i++)
    begin
      repeat (PER) @(negedge clk);
      b[i] = txd;
    end
    wait (txd === 1'b1);
    last_byte = b;
    n_bytes++;
  end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import ubgd_pkg::*;
  typedef struct {logic [7:0] c; int bits; logic dur, aft, wk;} ubgd_row_t;
  logic        CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RXD, TXD, IRQ, WAKE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        er, space, clr;
  logic [7:0]  last_byte;
  int          max_low, n_bytes, errors, checks;
  ubgd_row_t   rows[7] = '{'{8'h08, 13, 1, 1, 0}, '{8'h08, 9, 0, 0, 0}, '{8'h00, 13, 0, 1, 0},
    '{8'h88, 21, 0, 0, 0}, '{8'h88, 25, 1, 1, 0}, '{8'h10, 13, 0, 0, 1}, '{8'h28, 13, 0, 0, 0}};
  ubgd_top uut (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .RXD, .TXD, .IRQ, .WAKE);
  ubgd_node #(.PER(4)) node (.clk(CLK), .clr, .space, .txd(TXD), .rxd(RXD), .max_low, .n_bytes, .last_byte);
  always #25 CLK = ~CLK;
  // **********
  // Tasks
  // **********
  task report_and_stop;
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Read data and the error bit are taken at the rising edge that samples ready high, and released only then.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    n = 0;
    do @(posedge CLK); while (PREADY !== 1'b1 && ++n < 50);
    rd = PRDATA;
    er = PSLVERR;
    if (n >= 50)
    begin
      errors++;
      $display("mismatch %0t no ready", $time);
    end
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task tx_case(input logic [7:0] c, input logic [7:0] d, input int lo, input int nb);
    int n0;
    n0 = n_bytes;
    clr <= 1;
    apb(1, OFS_CTRL, {24'h0, c});
    clr <= 0;
    apb(1, OFS_TXBUF, {24'h0, d});
    apb(0, OFS_STAT, 0); chk(rd & 32'h2, 0);
    for (int n = 0; n < 900 && n_bytes < n0 + nb; n++) @(posedge CLK);
    repeat (12) @(posedge CLK);
    chk(32'(n_bytes - n0), 32'(nb));
    chk({24'h0, last_byte}, {24'h0, d});
    chk(32'(max_low), 32'(lo));
    apb(0, OFS_STAT, 0); chk(rd & 32'h2, 32'h2);
    apb(1, OFS_FLAGS, 32'h7);
  endtask
  task irq_is(input logic e);
    repeat (2) @(negedge CLK);
    chk({31'h0, IRQ}, {31'h0, e});
  endtask
  // **********
  // Sequence
  // **********
  initial
  begin
    {CLK, RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, space, clr, errors, checks} = '0;
    repeat (6) @(posedge CLK);
    RSTN <= 1;
    apb(1, OFS_BAUD, 3);
    foreach (rows[k])
    begin
      apb(1, OFS_CTRL, {24'h0, rows[k].c});
      space <= 1;
      repeat (rows[k].bits * 4) @(posedge CLK);
      @(negedge CLK); chk({31'h0, WAKE}, {31'h0, rows[k].wk});
      apb(0, OFS_FLAGS, 0); chk(rd & 32'h1, {31'h0, rows[k].dur});
      space <= 0;
      repeat (16) @(posedge CLK);
      apb(0, OFS_FLAGS, 0); chk(rd & 32'h1, {31'h0, rows[k].aft});
      apb(1, OFS_FLAGS, 32'h7);
      apb(0, OFS_FLAGS, 0); chk(rd & 32'h1, 0);
    end
    apb(1, OFS_MASK, 1);
    apb(1, OFS_CTRL, 32'h8);
    space <= 1;
    repeat (60) @(posedge CLK);
    space <= 0;
    irq_is(1);
    apb(1, OFS_MASK, 0);
    irq_is(0);
    apb(1, OFS_MASK, 1);
    irq_is(1);
    apb(1, OFS_FLAGS, 1);
    irq_is(0);
    apb(1, OFS_CTRL, 32'h5);
    repeat (10) @(negedge CLK); chk({31'h0, TXD}, 0);
    apb(1, OFS_CTRL, 32'h1);
    repeat (3) @(negedge CLK); chk({31'h0, TXD}, 1);
    // The held low level looks like a frame to the node; let it finish before counting frames.
    repeat (40) @(posedge CLK);
    tx_case(8'h03, 8'hA5, 52, 2);
    apb(0, OFS_CTRL, 0); chk(rd, 32'h1);
    tx_case(8'h01, 8'h55, 4, 1);
    tx_case(8'h43, 8'hA5, 52, 2);
    tx_case(8'h83, 8'hA5, 52, 2);
    RSTN <= 0;
    repeat (6) @(posedge CLK);
    RSTN <= 1;
    apb(0, OFS_CTRL, 0); chk(rd, 0);
    apb(0, OFS_BAUD, 0); chk(rd, 32'h10);
    apb(0, OFS_MASK, 0); chk(rd, 0);
    apb(0, OFS_FLAGS, 0); chk(rd, 0);
    apb(0, OFS_STAT, 0); chk(rd, 32'h3);
    apb(1, 12'h018, 1); chk({31'h0, er}, 1);
    apb(0, 12'h018, 0); chk(rd, 0);
    report_and_stop;
  end
  // The span allows the whole sequence more than twenty times over.
  initial
  begin
    repeat (30000) @(posedge CLK);
    errors++;
    report_and_stop;
  end
endmodule
bind ubgd_top ubgd_top_asserts chk_i (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PREADY, .PSLVERR, .RXD, .TXD, .IRQ, .WAKE);
